// ===== inc/sfspi_pkg.sv
// ==========================================================
// Constants for the serial flash pin interface
// ==========================================================
package sfspi_pkg;
    // Array geometry
    localparam int PAGE_BYTES   = 256;
    localparam int SECTOR_PAGES = 16;
    localparam int BLOCK_PAGES  = 256;
    localparam int SECTOR_BYTES = PAGE_BYTES * SECTOR_PAGES;
    localparam int SECT_AW      = 12;        // log2 of sector bytes
    localparam int DENSITY_PAGES_DEF = 512;  // Smallest variant
    // Backing store holds only the low address bits (aliases)
    localparam int MEM_AW    = 13;
    localparam int MEM_BYTES = 1 << MEM_AW;
    localparam logic [MEM_AW:0] ER_LEN_SECT = 14'h1000;
    localparam logic [MEM_AW:0] ER_LEN_ALL  = 14'h2000;
    // Clock rates; link clock is sampled, so far below its limit
    localparam int CLK_HZ     = 50_000_000;
    localparam int SCK_MAX_HZ = 100_000_000;
    // Instruction codes
    localparam logic [7:0] OP_WRSR  = 8'h01;
    localparam logic [7:0] OP_PROG  = 8'h02;
    localparam logic [7:0] OP_READ  = 8'h03;
    localparam logic [7:0] OP_WRDI  = 8'h04;
    localparam logic [7:0] OP_RDSR  = 8'h05;
    localparam logic [7:0] OP_WREN  = 8'h06;
    localparam logic [7:0] OP_FAST  = 8'h0b;
    localparam logic [7:0] OP_SE    = 8'h20;
    localparam logic [7:0] OP_DUAL  = 8'h3b;
    localparam logic [7:0] OP_JEDEC = 8'h9f;
    localparam logic [7:0] OP_CE    = 8'hc7;
    localparam logic [7:0] OP_BE    = 8'hd8;
    // Status byte field positions
    localparam int ST_BUSY  = 0;
    localparam int ST_WEL   = 1;
    localparam int ST_BP_LO = 2;
    localparam int ST_TB    = 5;
    localparam int ST_LOCK  = 7;
    // Identification bytes, values arbitrary
    localparam logic [7:0] MANUF_ID = 8'h5a;
    localparam logic [7:0] DEV_TYPE = 8'h30;
    localparam logic [7:0] DEV_CAP  = 8'h11;
    // Transaction phases
    typedef enum logic [2:0] {
        ST_OPC   = 3'b000,
        ST_ADDR  = 3'b001,
        ST_DUMMY = 3'b010,
        ST_OUT   = 3'b011,
        ST_IN    = 3'b100,
        ST_SKIP  = 3'b101
    } sfspi_state_t;
endpackage

// ===== inc/sfspi_mem_if.sv
`timescale 1ns/10ps
// ==========================================================
// Link between transaction logic and byte storage
// ==========================================================
interface sfspi_mem_if;
    import sfspi_pkg::*;
    logic [MEM_AW-1:0] addr;        // Byte index
    logic [7:0]        wdata;       // Program byte
    logic              we;          // Program strobe
    logic [7:0]        rdata;       // Byte at addr
    logic              erase_go;    // Erase start pulse
    logic [MEM_AW-1:0] erase_base;  // First erased index
    logic [MEM_AW:0]   erase_len;   // Bytes to erase
    logic              busy;        // Erase in progress
    modport ctl (output addr, wdata, we, erase_go, erase_base,
                 erase_len, input rdata, busy);
    modport mem (input addr, wdata, we, erase_go, erase_base,
                 erase_len, output rdata, busy);
endinterface

// ===== logic/sfspi_array.sv
`timescale 1ns/10ps
// ==========================================================
// Byte storage with serial erase engine
// ==========================================================
module sfspi_array (
    input wire logic CLK,
    input wire logic SYS_RST,
    sfspi_mem_if.mem mif
);
    import sfspi_pkg::*;

    logic [7:0]        mem [MEM_BYTES];  // Storage bytes
    logic [MEM_AW-1:0] eptr;             // Erase pointer
    logic [MEM_AW:0]   erem;             // Bytes left to erase

    wire erasing = (erem != '0);

    assign mif.busy  = erasing;
    assign mif.rdata = mem[mif.addr];

    // Erase walker: one byte per clock, keeps logic small
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            eptr <= '0;
            erem <= '0;
        end else if (erasing) begin
            eptr <= eptr + 1'b1;
            erem <= erem - 1'b1;
        end else if (mif.erase_go) begin
            eptr <= mif.erase_base;
            erem <= mif.erase_len;
        end
    end

    // Per-byte cell: erase sets ones, program only clears bits
    genvar i;
    generate
        for (i = 0; i < MEM_BYTES; i++) begin : g_cell
            always_ff @(posedge CLK or posedge SYS_RST) begin
                if (SYS_RST) begin
                    mem[i] <= 8'hff;
                end else if (erasing && eptr == MEM_AW'(i)) begin
                    mem[i] <= 8'hff;
                end else if (mif.we && mif.addr == MEM_AW'(i)) begin
                    mem[i] <= mem[i] & mif.wdata;
                end
            end
        end
    endgenerate
endmodule

// ===== logic/sfspi_top.sv
`timescale 1ns/10ps
// Functional notes
// [RL1] Select high: deselected, output pin floats
// [RL2] Select low: accept instructions, return data
// [RL3] No instruction before first select falling edge
// [RL4] Output bits change on clock falling edges
// [RL5] Input bits captured on clock rising edges
// [RL6] Dual read also drives the io pin
// [RL7] Pause low: outputs float, clock ignored
// [RL8] Pause release resumes with state intact
// [RL9] Write guard low with lock blocks status
// [RL10] Page program wraps within 256-byte page
// [RL11] Sector, block and chip erase ranges
// [RL12] Density variant sets pages and blocks
// [RL13] Clock limit 100MHz, dual doubles bits; sampling SCK at CLK keeps the link far below it
// [RL14] Maker and device codes readable
// [RL15] Modes 0 and 3 both supported
// [RL16] Code 3b selects dual output read
// [RL17] Pause changes only while clock low
// [RL18] Locked protect bits not writable
// [RL19] Read address increments after each byte
// [RL20] Host keeps select low during pause
module sfspi_top #(
    parameter int DENSITY_PAGES = sfspi_pkg::DENSITY_PAGES_DEF
) (
    input  wire logic CLK,
    input  wire logic SYS_RST,
    input  wire logic CS_N,
    input  wire logic SCK,
    input  wire logic HOLD_N,
    input  wire logic WP_N,
    input  wire logic SERIAL_IO_PIN_IN,
    output logic      SERIAL_IO_PIN_OUT,
    output logic      SERIAL_IO_PIN_OE,
    output logic      DO_OUT,
    output logic      DO_OE
);
    import sfspi_pkg::*;

    // ======================================================
    // Pin synchronisers and edge detection
    // ======================================================
    logic [4:0] pin_meta;  // First stage, read by second only
    logic [4:0] pin_sync;  // Settled pin levels
    logic       cs_d;      // Previous select level
    logic       sck_d;     // Previous clock level

    wire [4:0] pin_raw = {CS_N, SCK, HOLD_N, WP_N, SERIAL_IO_PIN_IN};

    // Two flops per pin; reset low so a select edge is real
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    // Edge history
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cs_d  <= 1'b0;
            sck_d <= 1'b0;
        end else begin
            cs_d  <= pin_sync[4];
            sck_d <= pin_sync[3];
        end
    end

    wire cs_s     = pin_sync[4];
    wire sck_s    = pin_sync[3];
    wire hold_n_s = pin_sync[2];
    wire wp_n_s   = pin_sync[1];
    wire io_s     = pin_sync[0];
    // Edges only, so either idle level works [RL15]
    wire sck_rise = sck_s & ~sck_d;
    wire sck_fall = ~sck_s & sck_d;
    wire cs_fall  = ~cs_s & cs_d;
    wire cs_rise  = cs_s & ~cs_d;
    // Sampling at CLK limits the link far below SCK_MAX_HZ [RL13]

    // ======================================================
    // Arming and pause
    // ======================================================
    logic armed;  // Select edge seen since reset
    logic hold;   // Pause in force

    // Arm on first high-to-low select transition [RL3]
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            armed <= 1'b0;
        end else if (cs_fall) begin
            armed <= 1'b1;
        end
    end

    // Pause follows pin only while clock low [RL7] [RL17]
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            hold <= 1'b0;
        end else if (cs_s) begin
            hold <= 1'b0;
        end else if (!sck_s) begin
            hold <= ~hold_n_s;
        end
    end

    // Clock edges reach the logic only when selected and live
    wire active = ~cs_s & armed & ~hold;  // [RL2] [RL8]
    wire rx     = active & sck_rise;      // [RL5]
    wire tx     = active & sck_fall;      // [RL4]

    // ======================================================
    // Transaction state
    // ======================================================
    sfspi_state_t state;       // Phase
    sfspi_state_t next_state;  // Phase after a byte
    logic [7:0]   opcode;      // Current instruction
    logic [6:0]   in_sr;       // Partial input byte
    logic [2:0]   bit_cnt;     // Bits of current byte
    logic [1:0]   adr_cnt;     // Address bytes taken
    logic [23:0]  addr;        // Byte address
    logic         wel;         // Write enable latch
    logic [2:0]   bp;          // protect_range_bits
    logic         tb;          // Protect from bottom
    logic         lock;        // status_lock_bit

    sfspi_mem_if mif ();

    wire [7:0] rx_byte   = {in_sr, io_s};
    wire       byte_done = rx & (bit_cnt == 3'h7);
    wire       busy      = mif.busy;
    wire       wr_locked = lock & ~wp_n_s;  // [RL9] [RL18]
    wire       is_rd     = (opcode == OP_READ) | (opcode == OP_FAST)
                         | (opcode == OP_DUAL);
    wire       dual      = (opcode == OP_DUAL);  // [RL16]
    wire       is_adr_op = (rx_byte == OP_READ) | (rx_byte == OP_FAST)
                         | (rx_byte == OP_DUAL) | (rx_byte == OP_PROG)
                         | (rx_byte == OP_SE) | (rx_byte == OP_BE);

    // Protected blocks from density and range bits [RL12]
    wire [4:0] blocks = 5'(DENSITY_PAGES / BLOCK_PAGES);
    wire [4:0] pwide  = 5'h1 << (bp - 3'h1);
    wire [4:0] pcnt   = (bp == 3'h0) ? 5'h0 :
                        (bp == 3'h7 || pwide > blocks) ? blocks : pwide;
    wire [4:0] blk    = {1'b0, addr[19:16]};
    wire prot_hit = tb ? (blk < pcnt) : (blk >= blocks - pcnt);  // [RL9]

    wire [7:0] status_byte = {lock, 1'b0, tb, bp, wel, busy};

    // Phase after each completed byte
    always_comb begin
        next_state = state;
        if (byte_done) begin
            case (state)
                ST_OPC: begin
                    if (busy && rx_byte != OP_RDSR) begin
                        next_state = ST_SKIP;
                    end else if (rx_byte == OP_RDSR ||
                                 rx_byte == OP_JEDEC) begin
                        next_state = ST_OUT;
                    end else if (rx_byte == OP_WRSR) begin
                        // Locked status ignores the data byte
                        next_state = (wel && !wr_locked) ? ST_IN
                                                         : ST_SKIP;
                    end else if (is_adr_op) begin
                        next_state = ST_ADDR;
                    end else begin
                        next_state = ST_SKIP;
                    end
                end
                ST_ADDR: begin
                    if (adr_cnt == 2'h2) begin
                        if (opcode == OP_READ) begin
                            next_state = ST_OUT;
                        end else if (opcode == OP_FAST || dual) begin
                            next_state = ST_DUMMY;
                        end else if (opcode == OP_PROG && wel) begin
                            next_state = ST_IN;
                        end else begin
                            next_state = ST_SKIP;
                        end
                    end
                end
                ST_DUMMY: next_state = ST_OUT;
                ST_IN: begin
                    // Status takes one byte only
                    if (opcode == OP_WRSR) begin
                        next_state = ST_SKIP;
                    end
                end
                default: next_state = state;
            endcase
        end
    end

    wire prog_wr = byte_done & (state == ST_IN) & (opcode == OP_PROG)
                 & ~prot_hit;
    wire sr_wr   = byte_done & (state == ST_IN) & (opcode == OP_WRSR);

    // ======================================================
    // Output shifter
    // ======================================================
    logic [7:0] out_sr;    // Remaining output bits
    logic [2:0] out_left;  // Bits left in byte
    logic [1:0] id_idx;    // Identification byte index
    logic       do_bit;    // Output pin value
    logic       io_bit;    // Second output in dual mode
    logic       do_oe;     // Output pin enable
    logic       io_oe;     // io pin enable

    wire       out_phase = (state == ST_OUT);
    wire       load_out  = tx & out_phase & (out_left == 3'h0);
    wire [7:0] id_byte   = (id_idx == 2'h0) ? MANUF_ID :
                           (id_idx == 2'h1) ? DEV_TYPE : DEV_CAP;
    wire [7:0] src_byte  = (opcode == OP_RDSR)  ? status_byte :
                           (opcode == OP_JEDEC) ? id_byte : mif.rdata;
    wire [7:0] cur       = load_out ? src_byte : out_sr;
    wire [2:0] step      = dual ? 3'h2 : 3'h1;  // [RL13]

    // Sequencer; deselect aborts the transaction [RL1] [RL20]
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state   <= ST_OPC;
            opcode  <= 8'h00;
            in_sr   <= 7'h00;
            bit_cnt <= 3'h0;
            adr_cnt <= 2'h0;
            addr    <= 24'h000000;
        end else if (cs_s) begin
            state   <= ST_OPC;
            opcode  <= 8'h00;
            bit_cnt <= 3'h0;
            adr_cnt <= 2'h0;
        end else if (rx) begin
            state   <= next_state;
            in_sr   <= rx_byte[6:0];
            bit_cnt <= bit_cnt + 3'h1;  // [RL5]
            if (byte_done && state == ST_OPC) begin
                opcode <= rx_byte;
            end
            if (byte_done && state == ST_ADDR) begin
                addr    <= {addr[15:0], rx_byte};
                adr_cnt <= adr_cnt + 2'h1;
            end
            if (byte_done && state == ST_IN && opcode == OP_PROG) begin
                addr[7:0] <= addr[7:0] + 8'h01;  // [RL10]
            end
        end else if (load_out && is_rd) begin
            addr <= addr + 24'h000001;  // [RL19]
        end
    end

    // Write latch and status bits
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wel  <= 1'b0;
            bp   <= 3'h0;
            tb   <= 1'b0;
            lock <= 1'b0;
        end else if (byte_done && state == ST_OPC && !busy &&
                     (rx_byte == OP_WREN || rx_byte == OP_WRDI)) begin
            wel <= (rx_byte == OP_WREN);
        end else if (sr_wr) begin
            lock <= rx_byte[ST_LOCK];  // [RL18]
            tb   <= rx_byte[ST_TB];
            bp   <= rx_byte[ST_BP_LO +: 3];
        end else if (cs_rise && (opcode == OP_PROG || opcode == OP_WRSR
                     || opcode == OP_SE || opcode == OP_BE
                     || opcode == OP_CE)) begin
            wel <= 1'b0;
        end
    end

    // Shift out on falling edges, two bits in dual mode [RL4] [RL6]
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            out_sr   <= 8'h00;
            out_left <= 3'h0;
            id_idx   <= 2'h0;
            do_bit   <= 1'b0;
            io_bit   <= 1'b0;
        end else if (cs_s) begin
            out_left <= 3'h0;
            id_idx   <= 2'h0;
        end else if (tx && out_phase) begin
            do_bit   <= cur[7];
            io_bit   <= cur[6];
            out_sr   <= dual ? {cur[5:0], 2'b00} : {cur[6:0], 1'b0};
            out_left <= load_out ? (dual ? 3'h6 : 3'h7) : out_left - step;
            if (load_out && opcode == OP_JEDEC) begin
                id_idx <= (id_idx == 2'h2) ? 2'h0 : id_idx + 2'h1;  // [RL14]
            end
        end
    end

    // Pin enables; float when deselected or paused [RL1] [RL7]
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            do_oe <= 1'b0;
            io_oe <= 1'b0;
        end else begin
            do_oe <= active & out_phase;
            io_oe <= active & out_phase & dual;  // [RL6]
        end
    end

    assign DO_OUT            = do_bit;
    assign DO_OE             = do_oe;
    assign SERIAL_IO_PIN_OUT = io_bit;
    assign SERIAL_IO_PIN_OE  = io_oe;

    // ======================================================
    // Storage and erase requests
    // ======================================================
    wire er_ok = cs_rise & wel & ~busy & (state == ST_SKIP)
               & (bit_cnt == 3'h0);
    wire se_go = er_ok & (opcode == OP_SE || opcode == OP_BE)
               & (adr_cnt == 2'h3) & ~prot_hit;
    wire ce_go = er_ok & (opcode == OP_CE) & (pcnt == 5'h0);

    // Store aliases above two sectors, so block and chip clear it all
    assign mif.addr       = addr[MEM_AW-1:0];
    assign mif.wdata      = rx_byte;
    assign mif.we         = prog_wr;
    assign mif.erase_go   = se_go | ce_go;  // [RL11]
    assign mif.erase_base = (opcode == OP_SE) ?
                            {addr[MEM_AW-1:SECT_AW], SECT_AW'(0)} : '0;
    assign mif.erase_len  = (opcode == OP_SE) ? ER_LEN_SECT : ER_LEN_ALL;

    sfspi_array u_array (
        .CLK     (CLK),
        .SYS_RST (SYS_RST),
        .mif     (mif.mem)
    );

    // ======================================================
    // Checks
    // ======================================================
    a_deselect_hiz: assert property (  // [RL1]
        @(posedge CLK) disable iff (SYS_RST)
        cs_s |=> !DO_OE && !SERIAL_IO_PIN_OE)
        else $error("output driven while deselected");
    a_unarmed_idle: assert property (  // [RL3]
        @(posedge CLK) disable iff (SYS_RST)
        !armed |=> bit_cnt == 3'h0 && state == ST_OPC)
        else $error("input taken before select edge");
    a_out_on_fall: assert property (  // [RL4]
        @(posedge CLK) disable iff (SYS_RST)
        $changed(do_bit) |-> $past(tx))
        else $error("output changed off a falling edge");
    a_in_on_rise: assert property (  // [RL5]
        @(posedge CLK) disable iff (SYS_RST)
        $changed(bit_cnt) |-> $past(rx) || $past(cs_s))
        else $error("bit counted off a rising edge");
    a_dual_only: assert property (  // [RL6]
        @(posedge CLK) disable iff (SYS_RST)
        SERIAL_IO_PIN_OE |-> $past(opcode) == OP_DUAL)
        else $error("io pin driven outside dual read");
    a_hold_float: assert property (  // [RL7]
        @(posedge CLK) disable iff (SYS_RST)
        hold |=> !DO_OE)
        else $error("output driven during pause");
    a_hold_keeps: assert property (  // [RL8]
        @(posedge CLK) disable iff (SYS_RST)
        hold && !cs_s |=> $stable(bit_cnt) && $stable(addr))
        else $error("state moved during pause");
    a_hold_clk_low: assert property (  // [RL17]
        @(posedge CLK) disable iff (SYS_RST)
        $changed(hold) |-> !$past(sck_s) || $past(cs_s))
        else $error("pause changed while clock high");
    a_lock_guard: assert property (  // [RL18]
        @(posedge CLK) disable iff (SYS_RST)
        lock && !wp_n_s && !cs_s ##1 !cs_s |-> $stable(bp))
        else $error("locked protect bits changed");
    a_page_wrap: assert property (  // [RL10]
        @(posedge CLK) disable iff (SYS_RST)
        prog_wr |=> addr[23:8] == $past(addr[23:8]))
        else $error("program left its page");
    a_read_incr: assert property (  // [RL19]
        @(posedge CLK) disable iff (SYS_RST)
        load_out && is_rd |=> addr == $past(addr) + 24'h000001)
        else $error("read address not advanced");
endmodule

// ===== tb/sfspi_host.sv
`timescale 1ns/10ps
// ========================
// Host SPI master, mode 0
module sfspi_host (
    input  wire logic CLK,
    input  wire logic DO_OUT,
    input  wire logic DO_OE,
    input  wire logic IO_OUT,
    input  wire logic IO_OE,
    output logic      SCK,
    output logic      CS_N,
    output logic      HOLD_N,
    output logic      IO_LVL
);
    logic drv = 1'b1; // Host drives io
    logic hb  = 1'b0; // Last host bit
    // Released io shows the inverse, never the stale bit
    assign IO_LVL = IO_OE ? IO_OUT : (drv ? hb : ~hb);
    // Select low from the start: no edge seen yet
    initial begin
        SCK    = 1'b0; // Idle low
        CS_N   = 1'b0;
        HOLD_N = 1'b1;
    end
    // One 160 ns clock; read back in mid high phase
    task automatic bit_x(input logic b, input logic rel,
                         output logic [1:0] r);
        SCK = 1'b0;
        drv = ~rel; // Let go in dual read
        hb  = b;
        repeat (4) @(negedge CLK); // Far below limit
        SCK = 1'b1; // Bit valid at rise
        repeat (2) @(negedge CLK);
        r = {DO_OE ? DO_OUT : ~hb, IO_LVL};
        repeat (2) @(negedge CLK);
    endtask
    // Byte out and in, MSB first; dual moves two bits a clock
    task automatic xb(input logic [7:0] t, input logic dual,
                      output logic [7:0] d);
        logic [1:0] r;
        d = 8'h00;
        for (int i = 7; i >= 0; i -= dual ? 2 : 1) begin
            bit_x(t[i], dual, r);
            d = dual ? {d[5:0], r} : {d[6:0], r[1]};
        end
    endtask
    // Select, opcode, then n address bytes
    task automatic op(input logic [7:0] c, input logic [23:0] ad,
                      input int n);
        logic [7:0] d;
        @(negedge CLK);
        CS_N = 1'b0;
        repeat (2) @(negedge CLK);
        xb(c, 1'b0, d);
        repeat (n) begin
            xb(ad[23:16], 1'b0, d);
            ad = ad << 8;
        end
    endtask
    // Park clock low, then set select and pause pins
    task automatic park(input logic cs, input logic hn);
        SCK = 1'b0;
        repeat (4) @(negedge CLK);
        CS_N   = cs; // Kept low over a pause
        HOLD_N = hn; // Changed with clock low
        repeat (5) @(negedge CLK);
    endtask
endmodule

// ===== tb/test_sfspi.sv
`timescale 1ns/10ps
// ========================
// Self-checking bench, random data
module test_sfspi;
    import sfspi_pkg::*;
    logic        CLK = 1'b0, SYS_RST = 1'b1, WP_N = 1'b1;
    logic        SCK, CS_N, HOLD_N, IO_LVL; // Host driven
    logic        IO_OUT, IO_OE, DO_OUT, DO_OE; // Device driven
    logic [7:0]  s, d[4];
    logic [23:0] a;
    int          seed = 36, error_cnt = 0, tests_run = 0;
    always #10 CLK = ~CLK;
    sfspi_top i_sfspi_top (.CLK(CLK), .SYS_RST(SYS_RST), .CS_N(CS_N),
        .SCK(SCK), .HOLD_N(HOLD_N), .WP_N(WP_N), .SERIAL_IO_PIN_IN(IO_LVL),
        .SERIAL_IO_PIN_OUT(IO_OUT), .SERIAL_IO_PIN_OE(IO_OE),
        .DO_OUT(DO_OUT), .DO_OE(DO_OE));
    sfspi_host i_host (.CLK(CLK), .DO_OUT(DO_OUT), .DO_OE(DO_OE),
        .IO_OUT(IO_OUT), .IO_OE(IO_OE), .SCK(SCK), .CS_N(CS_N),
        .HOLD_N(HOLD_N), .IO_LVL(IO_LVL));
    // Status byte with only the write latch varying
    function automatic logic [7:0] stat(logic wel);
        return {6'h00, wel, 1'b0};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Identification byte k; the three codes repeat
    function automatic logic [7:0] idb(int k);
        return (k % 3 == 0) ? MANUF_ID : (k % 3 == 1) ? DEV_TYPE : DEV_CAP;
    endfunction
    // One frame: opcode, n address bytes, one byte each way
    task automatic frame(input logic [7:0] c, input logic [23:0] ad,
                         input int n, input logic [7:0] t);
        i_host.op(c, ad, n);
        i_host.xb(t, 1'b0, s);
        i_host.park(1'b1, 1'b1);
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Watchdog, several times the expected run
    initial begin
        #1_000_000;
        error_cnt++;
        give_verdict();
    end
    // ========================
    // Main sequence
    initial begin
        repeat (6) @(negedge CLK);
        SYS_RST = 1'b0;
        // No select edge yet: this frame must be dropped
        i_host.xb(OP_WREN, 1'b0, s);
        chk(DO_OE, 8'h00);
        i_host.park(1'b1, 1'b1);
        i_host.op(OP_RDSR, a, 0);
        i_host.xb(8'h00, 1'b0, s);
        i_host.park(1'b1, 1'b1);
        chk(s, stat(1'b0));
        $display("select test done");
        // Program 4 random bytes across a page end
        a = {11'h000, 5'($random(seed)), 8'hfe};
        foreach (d[k]) d[k] = 8'($random(seed));
        i_host.op(OP_WREN, a, 0);
        i_host.park(1'b1, 1'b1);
        i_host.op(OP_PROG, a, 3);
        foreach (d[k]) i_host.xb(d[k], 1'b0, s);
        i_host.park(1'b1, 1'b1);
        i_host.op(OP_READ, a, 3);
        // Third byte is the next page, still erased
        for (int k = 0; k < 3; k++) begin
            i_host.xb(8'h00, 1'b0, s);
            chk(s, k < 2 ? d[k] : 8'hff);
        end
        i_host.park(1'b1, 1'b1);
        i_host.op(OP_READ, {a[23:8], 8'h00}, 3);
        i_host.xb(8'h00, 1'b0, s);
        chk(s, d[2]);
        // Pause between bytes; clocks inside must be ignored
        i_host.park(1'b0, 1'b0);
        chk(DO_OE, 8'h00);
        i_host.xb(8'h5a, 1'b0, s);
        i_host.park(1'b0, 1'b1);
        i_host.xb(8'h00, 1'b0, s);
        chk(s, d[3]);
        i_host.park(1'b1, 1'b1);
        $display("read and pause test done");
        // Fifth byte sent is the zero dummy
        i_host.op(OP_DUAL, a, 4);
        for (int k = 0; k < 2; k++) begin
            i_host.xb(8'h00, 1'b1, s);
            chk(s, d[k]);
        end
        chk(IO_OE, 8'h01);
        i_host.park(1'b1, 1'b1);
        chk(IO_OE, 8'h00);
        chk(DO_OE, 8'h00);
        $display("dual read test done");
        // Plain fast read uses the data pin alone, after a dummy
        frame(OP_FAST, a, 4, 8'h00);
        chk(s, d[0]);
        // Identification bytes wrap after the third
        i_host.op(OP_JEDEC, a, 0);
        for (int k = 0; k < 4; k++) begin
            i_host.xb(8'h00, 1'b0, s);
            chk(s, idb(k));
        end
        i_host.park(1'b1, 1'b1);
        // Write disable drops the latch again
        frame(OP_WREN, a, 0, 8'h00);
        frame(OP_WRDI, a, 0, 8'h00);
        frame(OP_RDSR, a, 0, 8'h00);
        chk(s, stat(1'b0));
        // Sector erase: busy at once, idle later, bytes back to ones
        frame(OP_WREN, a, 0, 8'h00);
        i_host.op(OP_SE, a, 3);
        i_host.park(1'b1, 1'b1);
        frame(OP_RDSR, a, 0, 8'h00);
        chk(s & 8'h03, 8'h01);
        repeat (4200) @(negedge CLK);
        frame(OP_RDSR, a, 0, 8'h00);
        chk(s, stat(1'b0));
        frame(OP_READ, a, 3, 8'h00);
        chk(s, 8'hff);
        // Lock with top block guarded, then pull the guard pin low
        frame(OP_WREN, a, 0, 8'h00);
        frame(OP_WRSR, a, 0, 8'h84);
        WP_N = 1'b0;
        frame(OP_WREN, a, 0, 8'h00);
        frame(OP_WRSR, a, 0, 8'h00);
        frame(OP_RDSR, a, 0, 8'h00);
        chk(s & 8'hfc, 8'h84);
        // Program into the guarded block aliases a; must be dropped
        frame(OP_WREN, a, 0, 8'h00);
        frame(OP_PROG, {8'h01, a[15:0]}, 3, 8'h00);
        frame(OP_READ, a, 3, 8'h00);
        chk(s, 8'hff);
        // Guard pin high again: status writable, protection off
        WP_N = 1'b1;
        frame(OP_WREN, a, 0, 8'h00);
        frame(OP_WRSR, a, 0, 8'h00);
        frame(OP_RDSR, a, 0, 8'h00);
        chk(s, stat(1'b0));
        $display("id, erase and guard test done");
        give_verdict();
    end
endmodule
